// ==== hdl/clock_control_map.vh ====
// register offsets, field positions, reset values and codes for the clock source select and divide block
`ifndef CLOCK_CONTROL_MAP_VH
`define CLOCK_CONTROL_MAP_VH

// register byte offsets
`define RING_CTRL_OFFSET     8'h00
`define SYS_CTRL1_OFFSET     8'h04
`define SYS_CTRL2_OFFSET     8'h08
`define OSC_CTRL_OFFSET      8'h0c
`define CLK_STATUS_OFFSET    8'h10

// reset values, loaded by reset and by power-up clear
`define RING_CTRL_RESET      8'h60
`define SYS_CTRL1_RESET      8'h84
`define SYS_CTRL2_RESET      8'h00
`define OSC_CTRL_RESET       8'h00

// ring control fields
`define STEP_SELECT_MSB      7
`define STEP_SELECT_LSB      5
`define STEP_MIX_MSB         4
`define STEP_MIX_LSB         0

// system control 1 fields
`define SECOND_OSC_DIS_BIT   7
`define CRYSTAL_SPEED_BIT    6
`define AUX_DIV_MSB          5
`define AUX_DIV_LSB          4
`define RANGE_SEL_MSB        2
`define RANGE_SEL_LSB        0

// system control 2 fields
`define MASTER_SEL_MSB       7
`define MASTER_SEL_LSB       6
`define MASTER_DIV_MSB       5
`define MASTER_DIV_LSB       4
`define SUBMAIN_SEL_MSB      3
`define SUBMAIN_SEL_LSB      2
`define SUBMAIN_DIV_MSB      1
`define SUBMAIN_DIV_LSB      0

// oscillator control fields
`define EXT_RESISTOR_BIT     0
`define CRYSTAL_OSC_DIS_BIT  1
`define RING_OSC_DIS_BIT     2

// source select codes
`define SRC_RING0            2'h0
`define SRC_RING1            2'h1
`define SRC_SECOND           2'h2
`define SRC_FIRST            2'h3

// ring oscillator step limits and modulation frame
`define STEP_MAX             3'h7
`define MIX_FRAME_LAST       5'h1f

// bus responses
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ==== hdl/clock_source_select_divide.v ====
// clock source selection, glitch-free switching, power-of-two division and ring oscillator control
// Behaviour
// - auxiliary clock is first crystal clock divided by 1, 2, 4 or 8
// - master clock selects first, second or ring clock, then divides by 1, 2, 4 or 8
// - sub-main clock selects first, second or ring clock, then divides by 1, 2, 4 or 8
// - without second oscillator, selecting second crystal delivers first crystal clock
// - power-up clear sources master and sub-main from ring, auxiliary low-frequency
// - crystal speed select 0 means low-frequency mode, 1 high-frequency mode
// - crystal disable stops first oscillator only if master and sub-main do not select first
// - second disable stops second oscillator only if master and sub-main unused
// - ring disable stops ring only if unused by sub-main and active master
// - power-up clear sets internal resistor, range 4 and step 3
// - external resistor select picks internal or external generator current resistor
// - three-bit range field picks one of eight ranges, zero lowest
// - three-bit step field splits range into eight steps, higher is faster
// - five-bit mix count alternates selected step with next higher step
// - at maximum step the mix count has no effect
// - mixing frame is 32 ring cycles, higher step for mix count cycles
// - source change finishes cycle, holds high until new rise, then follows
`timescale 1ns/1ps
`include "clock_control_map.vh"
module clock_source_select_divide #(
   parameter HAS_SECOND_OSC = 1
) (
   // clock and reset
   input  wire        ref_clk_in,
   input  wire        reset_n_in,
   // axi4-lite write address
   input  wire [7:0]  s_axi_awaddr_in,
   input  wire        s_axi_awvalid_in,
   output wire        s_axi_awready_out,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata_in,
   input  wire [3:0]  s_axi_wstrb_in,
   input  wire        s_axi_wvalid_in,
   output wire        s_axi_wready_out,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp_out,
   output reg         s_axi_bvalid_out,
   input  wire        s_axi_bready_in,
   // axi4-lite read address
   input  wire [7:0]  s_axi_araddr_in,
   input  wire        s_axi_arvalid_in,
   output wire        s_axi_arready_out,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata_out,
   output reg  [1:0]  s_axi_rresp_out,
   output reg         s_axi_rvalid_out,
   input  wire        s_axi_rready_in,
   // oscillator clocks and system state
   input  wire        first_crystal_clock_in,
   input  wire        second_crystal_clock_in,
   input  wire        ring_osc_clock_in,
   input  wire        power_up_clear_in,
   input  wire        active_mode_in,
   // generated clocks
   output wire        aux_clock_out,
   output wire        master_clock_out,
   output wire        submain_clock_out,
   // oscillator controls
   output reg         first_osc_enable_out,
   output reg         crystal_speed_select_out,
   output reg         second_osc_enable_out,
   output reg         ring_osc_enable_out,
   output reg         ext_resistor_select_out,
   output reg  [2:0]  range_resistor_select_out,
   output reg  [2:0]  step_select_out
);
   localparam SW_RUN    = 2'h0;
   localparam SW_FINISH = 2'h1;
   localparam SW_HOLD   = 2'h2;
   reg  [7:0]  ring_ctrl_r;
   reg  [7:0]  sys_ctrl1_r;
   reg  [7:0]  sys_ctrl2_r;
   reg  [2:0]  osc_ctrl_r;
   reg  [7:0]  aw_addr_r;
   reg         aw_full_r;
   reg  [31:0] w_data_r;
   reg  [3:0]  w_strb_r;
   reg         w_full_r;
   reg  [3:0]  lvl_prev_r;
   reg  [4:0]  mix_frame_r;
   wire [3:0]  lvl;
   wire [3:0]  rise;
   wire [1:0]  sw_out;
   wire [3:0]  cur_sel;
   wire [2:0]  div_out;
   wire [2:0]  div_src;
   wire [5:0]  div_ratio;
   wire        second_eff;
   wire        wr_fire;
   wire [2:0]  step_sel;
   wire [4:0]  mix_cnt;
   wire        first_used;
   wire        second_used;
   wire        ring_used;
   reg  [31:0] rd_val;
   reg  [1:0]  rd_resp;
   // without the second oscillator its select code falls back to the first crystal
   assign second_eff = (HAS_SECOND_OSC != 0) ? second_crystal_clock_in : first_crystal_clock_in;
   assign lvl  = {first_crystal_clock_in, second_eff, ring_osc_clock_in, ring_osc_clock_in};
   assign rise = lvl & ~lvl_prev_r;
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         lvl_prev_r <= 4'h0;
      end else begin
         lvl_prev_r <= lvl;
      end
   end
   assign s_axi_awready_out = !aw_full_r;
   assign s_axi_wready_out  = !w_full_r;
   assign s_axi_arready_out = !s_axi_rvalid_out;
   assign wr_fire = aw_full_r && w_full_r && !s_axi_bvalid_out;
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         aw_addr_r        <= 8'h00;
         aw_full_r        <= 1'b0;
         w_data_r         <= 32'h00000000;
         w_strb_r         <= 4'h0;
         w_full_r         <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= `RESP_OKAY;
         ring_ctrl_r      <= `RING_CTRL_RESET;
         sys_ctrl1_r      <= `SYS_CTRL1_RESET;
         sys_ctrl2_r      <= `SYS_CTRL2_RESET;
         osc_ctrl_r       <= 3'h0;
      end else begin
         if (s_axi_awvalid_in && !aw_full_r) begin
            aw_addr_r <= s_axi_awaddr_in;
            aw_full_r <= 1'b1;
         end
         if (s_axi_wvalid_in && !w_full_r) begin
            w_data_r <= s_axi_wdata_in;
            w_strb_r <= s_axi_wstrb_in;
            w_full_r <= 1'b1;
         end
         if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
         if (power_up_clear_in) begin
            ring_ctrl_r <= `RING_CTRL_RESET;
            sys_ctrl1_r <= `SYS_CTRL1_RESET;
            sys_ctrl2_r <= `SYS_CTRL2_RESET;
            osc_ctrl_r  <= 3'h0;
         end else if (wr_fire && w_strb_r[0]) begin
            if (aw_addr_r == `RING_CTRL_OFFSET) begin
               ring_ctrl_r <= w_data_r[7:0];
            end else if (aw_addr_r == `SYS_CTRL1_OFFSET) begin
               sys_ctrl1_r <= w_data_r[7:0];
            end else if (aw_addr_r == `SYS_CTRL2_OFFSET) begin
               sys_ctrl2_r <= w_data_r[7:0];
            end else if (aw_addr_r == `OSC_CTRL_OFFSET) begin
               osc_ctrl_r <= w_data_r[2:0];
            end
         end
         if (wr_fire) begin
            aw_full_r        <= 1'b0;
            w_full_r         <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            if (aw_addr_r == `RING_CTRL_OFFSET || aw_addr_r == `SYS_CTRL1_OFFSET ||
                aw_addr_r == `SYS_CTRL2_OFFSET || aw_addr_r == `OSC_CTRL_OFFSET ||
                aw_addr_r == `CLK_STATUS_OFFSET) begin
               s_axi_bresp_out <= `RESP_OKAY;
            end else begin
               s_axi_bresp_out <= `RESP_SLVERR;
            end
         end
      end
   end
   always @* begin
      rd_val  = 32'h00000000;
      rd_resp = `RESP_OKAY;
      if (s_axi_araddr_in == `RING_CTRL_OFFSET) begin
         rd_val[7:0] = ring_ctrl_r;
      end else if (s_axi_araddr_in == `SYS_CTRL1_OFFSET) begin
         rd_val[7:0] = sys_ctrl1_r;
      end else if (s_axi_araddr_in == `SYS_CTRL2_OFFSET) begin
         rd_val[7:0] = sys_ctrl2_r;
      end else if (s_axi_araddr_in == `OSC_CTRL_OFFSET) begin
         rd_val[2:0] = osc_ctrl_r;
      end else if (s_axi_araddr_in == `CLK_STATUS_OFFSET) begin
         rd_val[10:0] = {step_select_out, 1'b0, ring_osc_enable_out, second_osc_enable_out,
                         first_osc_enable_out, cur_sel};
      end else begin
         rd_resp = `RESP_SLVERR;
      end
   end
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out  <= 32'h00000000;
         s_axi_rresp_out  <= `RESP_OKAY;
      end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out  <= rd_val;
         s_axi_rresp_out  <= rd_resp;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
      end
   end
   // source switches: master (0) and sub-main (1)
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : sw
         reg  [1:0] st_r;
         reg  [1:0] cur_r;
         reg  [1:0] tgt_r;
         reg        out_r;
         wire [1:0] req = (g == 0) ? sys_ctrl2_r[`MASTER_SEL_MSB:`MASTER_SEL_LSB]
                                   : sys_ctrl2_r[`SUBMAIN_SEL_MSB:`SUBMAIN_SEL_LSB];
         always @(posedge ref_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               st_r  <= SW_RUN;
               cur_r <= `SRC_RING0;
               tgt_r <= `SRC_RING0;
               out_r <= 1'b0;
            end else begin
               case (st_r)
                  SW_RUN: begin
                     out_r <= lvl[cur_r];
                     if (req != cur_r) begin
                        st_r <= SW_FINISH;
                     end
                  end
                  // old source finishes its cycle; its next rise starts the hold-high phase
                  SW_FINISH: begin
                     out_r <= lvl[cur_r] | rise[cur_r];
                     if (rise[cur_r]) begin
                        tgt_r <= req;
                        st_r  <= SW_HOLD;
                     end
                  end
                  SW_HOLD: begin
                     out_r <= 1'b1;
                     if (rise[tgt_r]) begin
                        cur_r <= tgt_r;
                        st_r  <= SW_RUN;
                     end
                  end
                  default: st_r <= SW_RUN;
               endcase
            end
         end
         assign sw_out[g]            = out_r;
         assign cur_sel[2*g+1:2*g]   = cur_r;
      end
   endgenerate
   // dividers: aux (0), master (1), sub-main (2)
   assign div_src   = {sw_out[1], sw_out[0], first_crystal_clock_in};
   assign div_ratio = {sys_ctrl2_r[`SUBMAIN_DIV_MSB:`SUBMAIN_DIV_LSB],
                       sys_ctrl2_r[`MASTER_DIV_MSB:`MASTER_DIV_LSB],
                       sys_ctrl1_r[`AUX_DIV_MSB:`AUX_DIV_LSB]};
   generate
      for (g = 0; g < 3; g = g + 1) begin : dv
         reg        prev_r;
         reg  [2:0] cnt_r;
         reg  [1:0] ratio_r;
         reg        out_r;
         reg  [2:0] cnt_nxt;
         reg  [1:0] ratio_nxt;
         wire [2:0] lim = (3'h1 << ratio_r) - 3'h1;
         wire       src_rise = div_src[g] & ~prev_r;
         always @* begin
            cnt_nxt   = cnt_r;
            ratio_nxt = ratio_r;
            if (src_rise) begin
               if (cnt_r == lim) begin
                  cnt_nxt   = 3'h0;
                  // a new ratio only takes over at a period boundary
                  ratio_nxt = div_ratio[2*g+1:2*g];
               end else begin
                  cnt_nxt = cnt_r + 3'h1;
               end
            end
         end
         always @(posedge ref_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               prev_r  <= 1'b0;
               cnt_r   <= 3'h0;
               ratio_r <= 2'h0;
               out_r   <= 1'b0;
            end else begin
               prev_r  <= div_src[g];
               cnt_r   <= cnt_nxt;
               ratio_r <= ratio_nxt;
               if (ratio_nxt == 2'h0) begin
                  out_r <= div_src[g];
               end else begin
                  out_r <= (cnt_nxt < (3'h1 << (ratio_nxt - 2'h1)));
               end
            end
         end
         assign div_out[g] = out_r;
      end
   endgenerate
   assign aux_clock_out     = div_out[0];
   assign master_clock_out  = div_out[1];
   assign submain_clock_out = div_out[2];
   // a crystal counts as used while either switch runs on its select code or is moving to it; the ring counts for the master only in active mode
   assign first_used  = (cur_sel[1:0] == `SRC_FIRST) || (sw[0].tgt_r == `SRC_FIRST) ||
                        (cur_sel[3:2] == `SRC_FIRST) || (sw[1].tgt_r == `SRC_FIRST);
   assign second_used = (cur_sel[1:0] == `SRC_SECOND) || (sw[0].tgt_r == `SRC_SECOND) ||
                        (cur_sel[3:2] == `SRC_SECOND) || (sw[1].tgt_r == `SRC_SECOND);
   assign ring_used   = (!cur_sel[3] || !sw[1].tgt_r[1]) ||
                        (active_mode_in && (!cur_sel[1] || !sw[0].tgt_r[1]));
   assign step_sel    = ring_ctrl_r[`STEP_SELECT_MSB:`STEP_SELECT_LSB];
   assign mix_cnt     = ring_ctrl_r[`STEP_MIX_MSB:`STEP_MIX_LSB];
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         first_osc_enable_out      <= 1'b1;
         crystal_speed_select_out  <= 1'b0;
         second_osc_enable_out     <= 1'b0;
         ring_osc_enable_out       <= 1'b1;
         ext_resistor_select_out   <= 1'b0;
         range_resistor_select_out <= 3'h4;
         step_select_out           <= 3'h3;
         mix_frame_r               <= 5'h00;
      end else begin
         first_osc_enable_out      <= !osc_ctrl_r[`CRYSTAL_OSC_DIS_BIT] || first_used;
         crystal_speed_select_out  <= sys_ctrl1_r[`CRYSTAL_SPEED_BIT];
         second_osc_enable_out     <= (HAS_SECOND_OSC != 0) &&
                                      (!sys_ctrl1_r[`SECOND_OSC_DIS_BIT] || second_used);
         ring_osc_enable_out       <= !osc_ctrl_r[`RING_OSC_DIS_BIT] || ring_used;
         ext_resistor_select_out   <= osc_ctrl_r[`EXT_RESISTOR_BIT];
         range_resistor_select_out <= sys_ctrl1_r[`RANGE_SEL_MSB:`RANGE_SEL_LSB];
         // frame counts ring cycles; the higher step fills its first mix-count slots
         if (rise[0]) begin
            mix_frame_r <= (mix_frame_r == `MIX_FRAME_LAST) ? 5'h00 : mix_frame_r + 5'h01;
         end
         if ((mix_cnt != 5'h00) && (step_sel != `STEP_MAX) && (mix_frame_r < mix_cnt)) begin
            step_select_out <= step_sel + 3'h1;
         end else begin
            step_select_out <= step_sel;
         end
      end
   end
endmodule // clock_source_select_divide

// ==== testbench/osc_model.sv ====
// oscillator source model that runs only while enabled
`timescale 1ns/1ps
module osc_model #(
   parameter int HALF = 3
) (
   input  wire logic clk_in,
   input  wire logic en_in,
   output logic      osc_out
);
   int cnt = 0;
   initial osc_out = 1'b0;
   // a stopped oscillator stands at 0, so a stale level never looks like a live clock
   always @(posedge clk_in) begin
      if (!en_in) begin
         osc_out <= 1'b0;
         cnt <= 0;
      end else if (cnt == HALF - 1) begin
         osc_out <= ~osc_out;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // osc_model

// ==== testbench/clock_source_select_divide_checker.sv ====
// port-level assertions for the clock source select and divide block
`timescale 1ns/1ps
`include "clock_control_map.vh"
module clock_source_select_divide_checker (
   // clock and reset
   input wire        ref_clk_in,
   input wire        reset_n_in,
   // register bus
   input wire        s_axi_arvalid_in,
   input wire        s_axi_arready_out,
   input wire        s_axi_rvalid_out,
   input wire        s_axi_rready_in,
   input wire [31:0] s_axi_rdata_out,
   input wire        s_axi_bvalid_out,
   input wire        s_axi_bready_in,
   input wire [1:0]  s_axi_bresp_out,
   // sources and controls
   input wire        first_crystal_clock_in,
   input wire        second_crystal_clock_in,
   input wire        ring_osc_clock_in,
   input wire        power_up_clear_in,
   input wire        aux_clock_out,
   input wire        master_clock_out,
   input wire        submain_clock_out,
   input wire        first_osc_enable_out,
   input wire        ring_osc_enable_out,
   input wire        crystal_speed_select_out,
   input wire        ext_resistor_select_out,
   input wire [2:0]  range_resistor_select_out,
   input wire [2:0]  step_select_out
);
   logic [2:0] src_q;
   logic [3:0] first_up;
   logic [3:0] any_up;
   wire  [2:0] src = {ring_osc_clock_in, second_crystal_clock_in, first_crystal_clock_in};
   wire  [2:0] up = src & ~src_q;
   // a generated clock may rise only a few cycles after a source rose, whatever the ratio
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         src_q <= 3'h0;
         first_up <= 4'h0;
         any_up <= 4'h0;
      end else begin
         src_q <= src;
         first_up <= {first_up[2:0], up[0]};
         any_up <= {any_up[2:0], |up};
      end
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   chk_aux_rise_first: assert property ($rose(aux_clock_out) |-> |first_up)
      else $error("aux clock rose without a first crystal rise");
   chk_master_rise_src: assert property ($rose(master_clock_out) |-> |any_up)
      else $error("master clock rose without a source rise");
   chk_submain_rise_src: assert property ($rose(submain_clock_out) |-> |any_up)
      else $error("submain clock rose without a source rise");
   chk_clear_ring_cfg: assert property (power_up_clear_in |-> ##[1:2]
      (range_resistor_select_out == 3'h4 && step_select_out == 3'h3 && !ext_resistor_select_out))
      else $error("ring configuration not reloaded by clear");
   chk_clear_low_freq: assert property (power_up_clear_in |-> ##[1:2] !crystal_speed_select_out)
      else $error("crystal not in low frequency mode after clear");
   chk_clear_osc_on: assert property (power_up_clear_in |-> ##[1:3]
      (first_osc_enable_out && ring_osc_enable_out)) else $error("oscillators not running after clear");
   chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read data not valid one cycle after address");
   chk_read_busy: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read address accepted while data pending");
   chk_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped before taken");
   chk_write_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped before taken");
   cover property (s_axi_bvalid_out && s_axi_bready_in && s_axi_bresp_out == `RESP_SLVERR);
   cover property ($rose(master_clock_out));
   cover property (power_up_clear_in);
endmodule // clock_source_select_divide_checker
bind clock_source_select_divide clock_source_select_divide_checker clock_source_select_divide_checker_inst (.*);

// ==== testbench/clock_source_select_divide_tb_top.sv ====
// self-checking bench for the clock source select and divide block
`timescale 1ns/1ps
`include "clock_control_map.vh"
module clock_source_select_divide_tb_top;
   logic        ref_clk_in = 1'b0, reset_n_in = 1'b0, power_up_clear_in = 1'b0, active_mode_in = 1'b1;
   logic [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
   logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
   logic [3:0]  s_axi_wstrb_in = 4'hf;
   logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
   logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
   logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
   logic        first_crystal_clock_in, second_crystal_clock_in, ring_osc_clock_in;
   logic        aux_clock_out, master_clock_out, submain_clock_out, first_osc_enable_out;
   logic        second_osc_enable_out, ring_osc_enable_out, crystal_speed_select_out, ext_resistor_select_out;
   logic [2:0]  range_resistor_select_out, step_select_out;
   logic [31:0] seed = 32'h571b8a7c, v;
   logic [7:0]  regs [0:3];
   logic [7:0]  mt [4] = '{8'ha8, 8'he8, 8'h40, 8'h1f};
   int          fail_count = 0, n_checks = 0, p, hi, lo, e;
   wire  [2:0]  gclk = {submain_clock_out, master_clock_out, aux_clock_out};

   clock_source_select_divide clock_source_select_divide_inst (.*);
   osc_model #(.HALF(7)) first_osc_inst (.clk_in(ref_clk_in), .en_in(first_osc_enable_out),
      .osc_out(first_crystal_clock_in));
   osc_model #(.HALF(3)) second_osc_inst (.clk_in(ref_clk_in), .en_in(second_osc_enable_out),
      .osc_out(second_crystal_clock_in));
   osc_model #(.HALF(2)) ring_osc_inst (.clk_in(ref_clk_in), .en_in(ring_osc_enable_out),
      .osc_out(ring_osc_clock_in));

   always #25 ref_clk_in = ~ref_clk_in;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // expected {ring, second, first} enables; a crystal stays on while any consumer selects it, the ring for the master only if active
   function automatic logic [2:0] en_exp(input logic act);
      logic [1:0] m, s;
      m = regs[2][7:6];
      s = regs[2][3:2];
      return {!(regs[3][2] && !(s < 2'h2 || (m < 2'h2 && act))), !(regs[1][7] && m != 2'h2 && s != 2'h2),
         !(regs[3][1] && m != 2'h3 && s != 2'h3)};
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= dt;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge ref_clk_in);
         if (s_axi_awvalid_in && s_axi_awready_out) begin aw_ok = 1'b1; s_axi_awvalid_in <= 1'b0; end
         if (s_axi_wvalid_in && s_axi_wready_out) begin w_ok = 1'b1; s_axi_wvalid_in <= 1'b0; end
      end
      // late bready lets the response be seen waiting
      repeat (2) @(posedge ref_clk_in);
      s_axi_bready_in <= 1'b1;
      do @(posedge ref_clk_in); while (!s_axi_bvalid_out);
      s_axi_bready_in <= 1'b0;
      check("bresp", 32'(er), 32'(s_axi_bresp_out));
      if (a < 8'h10 && s_axi_wstrb_in[0]) regs[a[3:2]] = (a == `OSC_CTRL_OFFSET) ? dt[7:0] & 8'h07 : dt[7:0];
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      do @(posedge ref_clk_in); while (!s_axi_arready_out);
      s_axi_arvalid_in <= 1'b0;
      @(posedge ref_clk_in);
      s_axi_rready_in <= 1'b1;
      do @(posedge ref_clk_in); while (!s_axi_rvalid_out);
      s_axi_rready_in <= 1'b0;
      check("rdata", ed, s_axi_rdata_out);
      check("rresp", 32'(er), 32'(s_axi_rresp_out));
   endtask
   task automatic defaults();
      regs = '{`RING_CTRL_RESET, `SYS_CTRL1_RESET, `SYS_CTRL2_RESET, `OSC_CTRL_RESET};
      repeat (150) @(posedge ref_clk_in);
      for (int a = 0; a < 4; a++) rd(8'(a * 4), 32'(regs[a]), `RESP_OKAY);
      rd(`CLK_STATUS_OFFSET, 32'h350, `RESP_OKAY);
   endtask
   // counts, over 32 ring rises, how often the raised and the plain step are applied
   task automatic mix_count(input logic [2:0] s);
      logic l;
      int n;
      n = 0;
      hi = 0;
      lo = 0;
      l = 1'b1;
      while (n < 32) begin
         @(posedge ref_clk_in);
         if (ring_osc_clock_in && !l) begin
            n++;
            if (step_select_out === s + 3'h1) hi++;
            if (step_select_out === s) lo++;
         end
         l = ring_osc_clock_in;
      end
   endtask
   task automatic period(input int k);
      logic l;
      int n;
      n = 0;
      p = 0;
      l = 1'b1;
      while (n < 2) begin
         @(posedge ref_clk_in);
         if (gclk[k] && !l) n++;
         if (n == 1) p++;
         l = gclk[k];
      end
   endtask

   initial begin
      repeat (40000) @(posedge ref_clk_in);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      repeat (16) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      @(posedge ref_clk_in);
      defaults();
      wr(8'h14, 32'h5a, `RESP_SLVERR);
      rd(8'h14, 32'h0, `RESP_SLVERR);
      for (int i = 0; i < 24; i++) begin
         v = rnd();
         // keep the ring awake until a master switch off it has landed
         active_mode_in <= 1'b1;
         s_axi_wstrb_in <= {3'h7, v[13]};
         wr({4'h0, v[9:8], 2'b00}, v, `RESP_OKAY);
         repeat (40) @(posedge ref_clk_in);
         active_mode_in <= v[12];
         repeat (150) @(posedge ref_clk_in);
         check("enables", 32'(en_exp(v[12])), {29'h0, ring_osc_enable_out, second_osc_enable_out,
            first_osc_enable_out});
         check("speed", 32'(regs[1][6]), 32'(crystal_speed_select_out));
         check("range", 32'(regs[1][2:0]), 32'(range_resistor_select_out));
         check("ext res", 32'(regs[3][0]), 32'(ext_resistor_select_out));
         rd({4'h0, v[9:8], 2'b00}, 32'(regs[v[9:8]]), `RESP_OKAY);
      end
      // park on the other ring code with the external resistor, so the clear must restore both
      s_axi_wstrb_in <= 4'hf;
      wr(`SYS_CTRL2_OFFSET, 32'h44, `RESP_OKAY);
      wr(`OSC_CTRL_OFFSET, 32'h1, `RESP_OKAY);
      repeat (100) @(posedge ref_clk_in);
      power_up_clear_in <= 1'b1;
      @(posedge ref_clk_in);
      power_up_clear_in <= 1'b0;
      defaults();
      for (int dv = 0; dv < 4; dv++) begin
         wr(`SYS_CTRL1_OFFSET, 32'(8'h84 | (dv << 4)), `RESP_OKAY);
         wr(`SYS_CTRL2_OFFSET, {24'h0, `SRC_FIRST, 2'(dv), `SRC_SECOND, 2'(dv)}, `RESP_OKAY);
         repeat (300) @(posedge ref_clk_in);
         for (int k = 0; k < 3; k++) begin
            period(k);
            check("clock period", 32'(((k == 2) ? 6 : 14) << dv), 32'(p));
         end
      end
      foreach (mt[i]) begin
         wr(`RING_CTRL_OFFSET, 32'(mt[i]), `RESP_OKAY);
         repeat (200) @(posedge ref_clk_in);
         mix_count(mt[i][7:5]);
         e = (mt[i][7:5] == `STEP_MAX) ? 0 : int'(mt[i][4:0]);
         check("raised steps", 32'(e), 32'(hi));
         check("plain steps", 32'(32 - e), 32'(lo));
      end
      tally_and_finish();
   end
endmodule // clock_source_select_divide_tb_top
